// *** core/sfs_consts.svh ***
// Constants for the frame status queue: register indices, field positions, reset values.
// Assumes inclusion by bare name from the queue package and design module.
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH

// ----------------------------------------
// Register indices on the read/write port
// ----------------------------------------
`define SFS_RD_XFER_STATUS   4'h0
`define SFS_RD_RX_COND       4'h1
`define SFS_RD_VECTOR        4'h2
`define SFS_RD_PENDING       4'h3
`define SFS_RD_ALIAS_XFER    4'h4
`define SFS_RD_ALIAS_RXCOND  4'h5
`define SFS_RD_COUNT_LOWER   4'h6
`define SFS_RD_COUNT_UPPER   4'h7
`define SFS_RD_IRQ_STATUS    4'h8
`define SFS_RD_IRQ_MASK      4'h9
`define SFS_RD_EXT_STATUS    4'hF
`define SFS_WR_IRQ_STATUS    4'h8
`define SFS_WR_IRQ_MASK      4'h9
`define SFS_WR_FEATURE       4'hF

// ----------------------------------------
// Field positions and sizes
// ----------------------------------------
`define SFS_DEPTH            10
`define SFS_PTR_W            4
`define SFS_CNT_W            14
`define SFS_ENTRY_W          19
`define SFS_FEAT_ENABLE_BIT  2
`define SFS_EXT_ENABLE_BIT   2
`define SFS_UPPER_AVAIL_BIT  6
`define SFS_UPPER_OVF_BIT    7
`define SFS_IRQ_PUSH_BIT     0
`define SFS_IRQ_OVF_BIT      1
`define SFS_IRQ_W            2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SFS_FEATURE_RST      8'h00
`define SFS_IRQ_MASK_RST     2'h0

`endif

// *** core/sfs_frame_status_fifo.sv ***
// Frame status queue of one bit-oriented receive channel, with its register port.
// Assumes frame events and live status come from receive logic on the same clock.
//
// Summary of operation
// - Ten entries, 14-bit count plus five bits.
// - Queue works only when enabled in frame mode.
// - Pointers reset when disabled or reset.
// - Enable bit clears to zero on reset.
// - Disabled: registers four-seven mirror zero-three.
// - Extended status bit two shows enable.
// - Frame end pushes status and count.
// - CRC checker resets at each closing flag.
// - Abort end still pushes count, counter resets.
// - Eleventh unread frame end is an overrun.
// - Overflow flag clears only when disabled or reset.
// - Status and counts come from queue; status pops.
// - Upper count bit six shows data present.
// - Only residue, overrun, CRC error are stored.
// - Upper read latches empty; live source if empty, else queue.
// - Reads never pop beyond stored entries.
`timescale 1ns/1ps
`include "sfs_consts.svh"

module sfs_frame_status_fifo (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       channel_reset,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       frame_mode,
  input  wire logic       rx_char_done,
  input  wire logic       frame_end,
  input  wire logic       frame_abort,
  input  wire logic [7:0] live_rx_cond,
  input  wire logic [7:0] live_xfer_status,
  input  wire logic [7:0] live_vector,
  input  wire logic [7:0] live_pending,
  input  wire logic [7:0] live_ext_status,
  output logic            crc_check_reset,
  output logic            irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  sfs_pkg::sfs_entry_s            mem_reg [`SFS_DEPTH];
  sfs_pkg::sfs_entry_s            mem_wdata;
  logic [7:0]                     feature_reg, feature_next;
  logic [`SFS_PTR_W-1:0]          wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [`SFS_PTR_W:0]            level_reg, level_next;
  logic                           ovf_reg, ovf_next;
  logic                           src_reg, src_next;
  logic [`SFS_CNT_W-1:0]          bytes_reg, bytes_next;
  logic [`SFS_IRQ_W-1:0]          irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [7:0]                     rdata_reg, rdata_next;
  logic                           crc_rst_reg, crc_rst_next;
  logic                           q_on, push, pop, full, empty, mem_we;
  sfs_pkg::sfs_entry_s            head;

  // Pointer wrap at queue depth
  function automatic logic [`SFS_PTR_W-1:0] ptr_inc(input logic [`SFS_PTR_W-1:0] p);
    ptr_inc = (p == `SFS_PTR_W'(`SFS_DEPTH - 1)) ? '0 : p + `SFS_PTR_W'(1);
  endfunction

  // ----------------------------------------
  // Queue control
  // ----------------------------------------
  // Queue active only with enable bit and frame mode
  assign q_on  = feature_reg[`SFS_FEAT_ENABLE_BIT] & frame_mode;
  assign full  = (level_reg == (`SFS_PTR_W+1)'(`SFS_DEPTH));
  assign empty = (level_reg == '0);
  assign head  = mem_reg[rptr_reg];
  assign push  = q_on & frame_end & ~full & ~ovf_reg;
  assign pop   = q_on & reg_rd & (reg_addr == `SFS_RD_RX_COND)
               & (src_reg == 1'b1) & ~empty;
  // Only stored bits; all-sent, parity and end bits stay live
  assign mem_wdata = '{residue: live_rx_cond[3:1], rx_overrun: live_rx_cond[5],
                       crc_error: live_rx_cond[6], count: bytes_reg};
  assign mem_we = push;

  // Next queue state
  always_comb begin
    wptr_next  = wptr_reg;
    rptr_next  = rptr_reg;
    level_next = level_reg;
    ovf_next   = ovf_reg;
    src_next   = src_reg;
    if (push) begin
      wptr_next = ptr_inc(wptr_reg);
    end
    if (pop) begin
      rptr_next = ptr_inc(rptr_reg);
    end
    level_next = level_reg + (`SFS_PTR_W+1)'(push) - (`SFS_PTR_W+1)'(pop);
    if (q_on & frame_end & full) begin
      ovf_next = 1'b1;
    end
    // Upper count read latches source: live when empty
    if (reg_rd & (reg_addr == `SFS_RD_COUNT_UPPER)) begin
      src_next = ~empty;
    end else if (pop) begin
      src_next = 1'b0;
    end
    if (!q_on) begin
      wptr_next  = '0;
      rptr_next  = '0;
      level_next = '0;
      ovf_next   = 1'b0;
      src_next   = 1'b0;
    end
  end

  // Register queue state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      level_reg <= '0;
      ovf_reg   <= 1'b0;
      src_reg   <= 1'b0;
    end else if (channel_reset) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      level_reg <= '0;
      ovf_reg   <= 1'b0;
      src_reg   <= 1'b0;
    end else begin
      wptr_reg  <= wptr_next;
      rptr_reg  <= rptr_next;
      level_reg <= level_next;
      ovf_reg   <= ovf_next;
      src_reg   <= src_next;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem_reg[wptr_reg] <= mem_wdata;
    end
  end

  // ----------------------------------------
  // Byte counter and CRC reset
  // ----------------------------------------
  // Count characters; clear at frame end or abort
  always_comb begin
    bytes_next   = bytes_reg;
    crc_rst_next = frame_end;
    if (frame_end | frame_abort) begin
      bytes_next = '0;
    end else if (rx_char_done) begin
      bytes_next = bytes_reg + `SFS_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bytes_reg   <= '0;
      crc_rst_reg <= 1'b0;
    end else if (channel_reset) begin
      bytes_reg   <= '0;
      crc_rst_reg <= 1'b0;
    end else begin
      bytes_reg   <= bytes_next;
      crc_rst_reg <= crc_rst_next;
    end
  end

  assign crc_check_reset = crc_rst_reg;

  // ----------------------------------------
  // Control and interrupt registers
  // ----------------------------------------
  always_comb begin
    feature_next  = feature_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (reg_wr && reg_addr == `SFS_WR_FEATURE) begin
      feature_next = reg_wdata;
    end
    if (reg_wr && reg_addr == `SFS_WR_IRQ_MASK) begin
      irq_mask_next = reg_wdata[`SFS_IRQ_W-1:0];
    end
    if (reg_wr && reg_addr == `SFS_WR_IRQ_STATUS) begin
      irq_stat_next = irq_stat_reg & ~reg_wdata[`SFS_IRQ_W-1:0];
    end
    // Set wins over clear
    if (push) begin
      irq_stat_next[`SFS_IRQ_PUSH_BIT] = 1'b1;
    end
    if (q_on & frame_end & full) begin
      irq_stat_next[`SFS_IRQ_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      feature_reg  <= `SFS_FEATURE_RST;
      irq_mask_reg <= `SFS_IRQ_MASK_RST;
      irq_stat_reg <= '0;
    end else if (channel_reset) begin
      feature_reg  <= `SFS_FEATURE_RST;
      irq_mask_reg <= `SFS_IRQ_MASK_RST;
      irq_stat_reg <= '0;
    end else begin
      feature_reg  <= feature_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `SFS_RD_XFER_STATUS: rdata_next = live_xfer_status;
        `SFS_RD_RX_COND: begin
          rdata_next = live_rx_cond;
          if (q_on && src_reg && !empty) begin
            rdata_next = {live_rx_cond[7], head.crc_error, head.rx_overrun,
                          live_rx_cond[4], head.residue, live_rx_cond[0]};
          end
        end
        `SFS_RD_VECTOR:       rdata_next = live_vector;
        `SFS_RD_PENDING:      rdata_next = live_pending;
        `SFS_RD_ALIAS_XFER:   rdata_next = live_xfer_status;
        `SFS_RD_ALIAS_RXCOND: rdata_next = live_rx_cond;
        `SFS_RD_COUNT_LOWER:  rdata_next = q_on ? head.count[7:0] : live_vector;
        `SFS_RD_COUNT_UPPER: begin
          rdata_next = live_pending;
          if (q_on) begin
            rdata_next = {ovf_reg, ~empty, head.count[13:8]};
          end
        end
        `SFS_RD_IRQ_STATUS: rdata_next = {6'h00, irq_stat_reg};
        `SFS_RD_IRQ_MASK:   rdata_next = {6'h00, irq_mask_reg};
        `SFS_RD_EXT_STATUS: begin
          rdata_next = live_ext_status;
          rdata_next[`SFS_EXT_ENABLE_BIT] = feature_reg[`SFS_FEAT_ENABLE_BIT];
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset | channel_reset);

  level_bound_a: assert property (level_reg <= (`SFS_PTR_W+1)'(`SFS_DEPTH))
    else $error("queue level above ten");
  no_underflow_a: assert property (empty && reg_rd && !push |=> level_reg == 0)
    else $error("queue popped while empty");
  push_level_a: assert property (push && !pop |=> level_reg == $past(level_reg) + 1)
    else $error("push did not add an entry");
  disabled_clear_a: assert property (!q_on |=> level_reg == 0 && !ovf_reg)
    else $error("queue state kept while disabled");
  ovf_sticky_a: assert property (ovf_reg && q_on && $stable(feature_reg) |=> ovf_reg)
    else $error("overflow flag cleared while enabled");
  ovf_set_a: assert property (q_on && frame_end && full |=> ovf_reg)
    else $error("overflow flag not set");
  ext_enable_a: assert property (reg_rd && reg_addr == `SFS_RD_EXT_STATUS
      |=> reg_rdata[`SFS_EXT_ENABLE_BIT] == $past(feature_reg[`SFS_FEAT_ENABLE_BIT]))
    else $error("enable readback wrong");
  alias_rx_a: assert property (reg_rd && reg_addr == `SFS_RD_ALIAS_RXCOND
      |=> reg_rdata == $past(live_rx_cond))
    else $error("alias register mismatch");
  avail_bit_a: assert property (q_on && reg_rd && reg_addr == `SFS_RD_COUNT_UPPER
      |=> reg_rdata[`SFS_UPPER_AVAIL_BIT] == $past(!empty))
    else $error("data available bit wrong");
  crc_reset_a: assert property (frame_end |=> crc_check_reset)
    else $error("crc reset pulse missing");
  count_clear_a: assert property (frame_abort |=> bytes_reg == 0)
    else $error("byte counter not cleared");

  fill_c: cover property (full);
  pop_c: cover property (pop);
  ovf_c: cover property (q_on && frame_end && full);
  irq_c: cover property (irq);

endmodule

// *** core/sfs_pkg.sv ***
// Types for the frame status queue.
// Assumes sfs_consts.svh is on the include path.
`include "sfs_consts.svh"

package sfs_pkg;
  // One queued entry: residue(3), rx overrun, crc error, byte count
  typedef struct packed {
    logic [2:0]               residue;
    logic                     rx_overrun;
    logic                     crc_error;
    logic [`SFS_CNT_W-1:0]    count;
  } sfs_entry_s;

  // Read path source selection
  typedef enum logic [1:0] {
    SFS_SRC_LIVE  = 2'b01,
    SFS_SRC_QUEUE = 2'b10
  } sfs_src_e;
endpackage

// *** tb/sfs_frame_status_fifo_tb.sv ***
// Testbench of the frame status queue: register port tasks and frame traffic.
// Assumes the receive stand-in model and the design on one 25 MHz clock.
`timescale 1ns/1ps

module sfs_frame_status_fifo_tb;
  logic clk = 1'b0, reset = 1'b1, channel_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, f_st = 8'h00;
  logic frame_mode = 1'b1, go = 1'b0, f_ab = 1'b0, busy, fe_q = 1'b0;
  logic rx_char_done, frame_end, frame_abort, crc_check_reset, irq;
  logic [13:0] f_n = 14'h0000;
  logic [7:0] live_rx_cond;
  int failures = 0, n_tests = 0;

  sfs_rx_model rx (.clk(clk), .reset(reset), .go(go), .n(f_n), .ab(f_ab), .st(f_st), .busy(busy),
    .rx_char_done(rx_char_done), .frame_end(frame_end), .frame_abort(frame_abort), .live_rx_cond(live_rx_cond));
  sfs_frame_status_fifo dut (.clk(clk), .reset(reset), .channel_reset(channel_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_mode(frame_mode),
    .rx_char_done(rx_char_done), .frame_end(frame_end), .frame_abort(frame_abort), .live_rx_cond(live_rx_cond),
    .live_xfer_status(8'h5A), .live_vector(8'h3C), .live_pending(8'hC3), .live_ext_status(8'hA0),
    .crc_check_reset(crc_check_reset), .irq(irq));

  // --------------
  // Bench helpers
  // --------------
  initial forever #20 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 1'b0;
    #1;
  endtask

  // Read and compare the masked data in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask

  task automatic fr(input logic [13:0] n, input logic ab, input logic [7:0] st);
    @(posedge clk) begin go <= 1'b1; f_n <= n; f_ab <= ab; f_st <= st; end
    @(posedge clk) go <= 1'b0;
    for (int k = 0; k < 1000; k++) begin
      @(posedge clk);
      #1;
      if (!busy) break;
    end
    if (busy) failures++;
  endtask

  task automatic finish_test;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Checker reset follows every frame end by one cycle
  always @(posedge clk) begin
    if (!reset && (fe_q || crc_check_reset)) chk(crc_check_reset, fe_q);
    fe_q <= frame_end;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test;
  end

  // ----------
  // Scenarios
  // ----------
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(4'hF, 8'hA0);
    rd(4'h4, 8'h5A);
    rd(4'h5, 8'h91);
    rd(4'h6, 8'h3C);
    rd(4'h7, 8'hC3);
    rd(4'hA, 8'h00);
    fr(14'd3, 1'b0, 8'h6E);
    rd(4'h8, 8'h00);
    wr(4'hF, 8'h04);
    wr(4'h9, 8'h03);
    rd(4'hF, 8'hA4);
    @(posedge clk) frame_mode <= 1'b0;
    fr(14'd2, 1'b0, 8'h6E);
    @(posedge clk) frame_mode <= 1'b1;
    rd(4'h7, 8'h00, 8'hC0);
    fr(14'd300, 1'b0, 8'h4A);
    chk(irq, 1'b1);
    wr(4'h9, 8'h00);
    chk(irq, 1'b0);
    wr(4'h9, 8'h03);
    fr(14'd3, 1'b1, 8'h26);
    rd(4'h1, 8'h91);
    rd(4'h7, 8'h41);
    rd(4'h6, 8'h2C);
    rd(4'h1, 8'hDB);
    rd(4'h7, 8'h40);
    rd(4'h6, 8'h03);
    rd(4'h1, 8'hB7);
    rd(4'h7, 8'h00, 8'hC0);
    rd(4'h1, 8'h91);
    rd(4'h1, 8'h91);
    rd(4'h8, 8'h01);
    wr(4'h8, 8'h01);
    rd(4'h8, 8'h00);
    chk(irq, 1'b0);
    // Eleven frames: the last one overruns the queue
    for (int i = 0; i < 11; i++) fr(14'(i + 1), 1'b0, i[0] ? 8'h40 : 8'h0C);
    rd(4'h7, 8'hC0, 8'hC0);
    rd(4'h8, 8'h03);
    chk(irq, 1'b1);
    wr(4'h8, 8'h03);
    chk(irq, 1'b0);
    for (int i = 0; i < 10; i++) begin
      rd(4'h7, 8'hC0);
      rd(4'h6, 8'(i + 1));
      rd(4'h1, i[0] ? 8'hD1 : 8'h9D);
    end
    fr(14'd2, 1'b0, 8'h40);
    rd(4'h7, 8'h80, 8'hC0);
    wr(4'hF, 8'h00);
    wr(4'hF, 8'h04);
    rd(4'h7, 8'h00, 8'hC0);
    fr(14'd1, 1'b0, 8'h40);
    @(posedge clk) channel_reset <= 1'b1;
    @(posedge clk) channel_reset <= 1'b0;
    rd(4'hF, 8'hA0);
    rd(4'h7, 8'hC3);
    finish_test;
  end
endmodule

// *** tb/sfs_rx_model.sv ***
// Receive-side stand-in: assembles a burst of characters, then ends the frame.
// Assumes the bench pulses go for one cycle and holds n, ab and st until busy falls.
`timescale 1ns/1ps

module sfs_rx_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        go,
  input  wire logic [13:0] n,
  input  wire logic        ab,
  input  wire logic [7:0]  st,
  output logic             busy,
  output logic             rx_char_done,
  output logic             frame_end,
  output logic             frame_abort,
  output logic [7:0]       live_rx_cond
);
  logic [13:0] left;
  logic        ph;

  // ----------------
  // Frame sequencer
  // ----------------
  // One character every other cycle, then a one-cycle frame end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy         <= 1'b0;
      left         <= 14'h0000;
      ph           <= 1'b0;
      rx_char_done <= 1'b0;
      frame_end    <= 1'b0;
      frame_abort  <= 1'b0;
      live_rx_cond <= 8'h91;
    end else begin
      rx_char_done <= 1'b0;
      frame_end    <= 1'b0;
      frame_abort  <= 1'b0;
      if (go) begin
        busy         <= 1'b1;
        left         <= n;
        ph           <= 1'b0;
        live_rx_cond <= st;  // Frame status shown live until the end
      end else if (busy) begin
        ph <= ~ph;
        if (left != 14'h0000) begin
          if (ph) begin
            rx_char_done <= 1'b1;
            left         <= left - 14'h0001;
          end
        end else if (!frame_end) begin
          frame_end   <= 1'b1;
          frame_abort <= ab;
        end else begin
          busy         <= 1'b0;
          live_rx_cond <= 8'h91;  // Idle live status differs from stored bits
        end
      end
    end
  end
endmodule
